// ===== design/tmr_chan_pkg.sv
// shared constants for the timer channel control block
package tmr_chan_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int        NUM_CH   = 8;
  localparam logic [7:0] CH_IMPL = 8'hFF;  // implemented channels
  localparam logic [7:0] REG_RST = 8'h00;  // reset value of every control register

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SELECT   = 8'h00;  // capture_compare_select
  localparam logic [7:0] OFS_DISC     = 8'h01;  // compare_pin_disconnect
  localparam logic [7:0] OFS_C7MASK   = 8'h02;  // ch7_compare_mask
  localparam logic [7:0] OFS_C7DATA   = 8'h03;  // ch7_compare_data
  localparam logic [7:0] OFS_TOV      = 8'h07;  // toggle_on_wrap_bit per channel
  localparam logic [7:0] OFS_ACT_HI   = 8'h08;  // output_action_ctrl_hi
  localparam logic [7:0] OFS_ACT_LO   = 8'h09;  // output_action_ctrl_lo
  localparam logic [7:0] OFS_EDGE_HI  = 8'h0A;  // edge_ctrl_hi
  localparam logic [7:0] OFS_EDGE_LO  = 8'h0B;  // edge_ctrl_lo
  localparam logic [7:0] OFS_IEN      = 8'h0C;  // channel_irq_enable
  localparam logic [7:0] OFS_FLAG     = 8'h0E;  // chan_flag_reg

  // ----------------------------------------------------------------
  // field codes: {out_mode_bit, out_level_bit} and {edge_sel_high_bit, edge_sel_low_bit}
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  localparam logic [1:0] EDGE_OFF   = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;
  localparam logic [1:0] EDGE_ANY   = 2'h3;

endpackage

// ===== design/capture_edge.sv
// one channel input: two-stage synchroniser and selectable edge detector
`timescale 1ns/1ps
module capture_edge
  import tmr_chan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel,
  output logic            edge_event
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;
  logic hit;

  // edge decode looks only at the second stage and its delayed copy
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign hit  = (edge_sel == EDGE_RISE) ? rise :
                (edge_sel == EDGE_FALL) ? fall :
                (edge_sel == EDGE_ANY)  ? (rise | fall) : 1'b0;

  // synchroniser, history and one-cycle event pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      prev_q     <= 1'b0;
      edge_event <= 1'b0;
    end else begin
      sync1_q    <= pin_in;
      sync2_q    <= sync1_q;
      prev_q     <= sync2_q;
      edge_event <= hit;
    end
  end

endmodule // capture_edge

// ===== design/compare_line.sv
// one channel compare output line with override, wrap toggle and action code
`timescale 1ns/1ps
module compare_line
  import tmr_chan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       own_match,
  input  wire logic       ovr_hit,
  input  wire logic       ovr_val,
  input  wire logic       wrap_tgl,
  input  wire logic [1:0] action,
  output logic            line_q
);

  logic line_d;

  // channel-7 override first, then wrap toggle, then own action
  always_comb begin
    line_d = line_q;
    if (ovr_hit) begin
      line_d = ovr_val;
    end else if (wrap_tgl) begin
      line_d = ~line_q;
    end else if (own_match) begin
      case (action)
        ACT_TOGGLE: line_d = ~line_q;
        ACT_CLEAR:  line_d = 1'b0;
        ACT_SET:    line_d = 1'b1;
        default:    line_d = line_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      line_q <= 1'b0;
    end else begin
      line_q <= line_d;
    end
  end

endmodule // compare_line

// ===== design/timer_channel_ctrl.sv
// channel control for an eight-channel timer: actions, edges, flags, interrupt
//
// Behaviour
// - compare match applies two-bit output action
// - nonzero action code turns pin to output
// - own action reaches pin when mask clear
// - disconnect bit stops compare driving pin
// - absent channels: writes ignored, reads zero
// - masked channel: equal takes data, later both
// - channel 7 self mask selects data bit
// - override only when both channels compare
// - edge code selects none, rise, fall, any
// - enable bit pairs with same flag bit
// - cleared enable blocks that flag's interrupt
// - capture or compare event sets channel flag
// - wrap toggle beats action, yields to override
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module timer_channel_ctrl
  import tmr_chan_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [7:0]          addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [7:0]          rdata,
  input  wire logic [NUM_CH-1:0]   compare_match,
  input  wire logic                counter_wrap,
  input  wire logic [NUM_CH-1:0]   pin_in,
  output logic      [NUM_CH-1:0]   pin_out,
  output logic      [NUM_CH-1:0]   pin_oe_n,
  output logic      [NUM_CH-1:0]   capture_event,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  select_q;
  logic [7:0]  disc_q;
  logic [7:0]  c7mask_q;
  logic [7:0]  c7data_q;
  logic [7:0]  tov_q;
  logic [15:0] act_q;
  logic [15:0] edge_q;
  logic [7:0]  ien_q;
  logic [7:0]  flag_q;
  logic [7:0]  flag_d;
  logic [7:0]  rdata_d;
  logic [7:0]  oe_n_d;
  logic [7:0]  cap_d;

  // ----------------------------------------------------------------
  // address decode and write data masked to implemented channels
  // ----------------------------------------------------------------
  wire [15:0] impl_pairs;
  wire [7:0]  wmask   = wdata & CH_IMPL;
  wire        we_sel  = wr && (addr == OFS_SELECT);
  wire        we_disc = wr && (addr == OFS_DISC);
  wire        we_c7m  = wr && (addr == OFS_C7MASK);
  wire        we_c7d  = wr && (addr == OFS_C7DATA);
  wire        we_tov  = wr && (addr == OFS_TOV);
  wire        we_ahi  = wr && (addr == OFS_ACT_HI);
  wire        we_alo  = wr && (addr == OFS_ACT_LO);
  wire        we_ehi  = wr && (addr == OFS_EDGE_HI);
  wire        we_elo  = wr && (addr == OFS_EDGE_LO);
  wire        we_ien  = wr && (addr == OFS_IEN);
  wire        we_flag = wr && (addr == OFS_FLAG);
  wire [15:0] wpair   = {wdata, wdata};
  wire [7:0]  wpair_hi = wpair[15:8] & impl_pairs[15:8];
  wire [7:0]  wpair_lo = wpair[7:0] & impl_pairs[7:0];

  // ----------------------------------------------------------------
  // per-channel datapath
  // ----------------------------------------------------------------
  wire [7:0] edge_hit;
  wire [7:0] line;
  wire [7:0] ovr_hit;
  wire [7:0] own_match;
  wire [7:0] wrap_tgl;
  wire [7:0] act_any;
  wire       c7_event = compare_match[7] & select_q[7];

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      assign impl_pairs[2*i+1:2*i] = {CH_IMPL[i], CH_IMPL[i]};
      assign act_any[i] = |act_q[2*i+1:2*i];
      // override needs both channels in compare mode
      assign ovr_hit[i] = c7_event & c7mask_q[i] & select_q[i];
      // channel 7 with its own mask bit set skips its own action
      assign own_match[i] = compare_match[i] & select_q[i]
                            & ~((i == 7) & c7mask_q[7]);
      assign wrap_tgl[i] = counter_wrap & tov_q[i] & select_q[i];

      compare_line u_line (
        .clk       (clk),
        .reset     (reset),
        .own_match (own_match[i]),
        .ovr_hit   (ovr_hit[i]),
        .ovr_val   (c7data_q[i]),
        .wrap_tgl  (wrap_tgl[i]),
        .action    (act_q[2*i+1:2*i]),
        .line_q    (line[i])
      );

      capture_edge u_edge (
        .clk        (clk),
        .reset      (reset),
        .pin_in     (pin_in[i]),
        .edge_sel   (edge_q[2*i+1:2*i]),
        .edge_event (edge_hit[i])
      );
    end
  endgenerate

  assign pin_out = line;

  // pin drives while an action or override is armed and not disconnected
  assign oe_n_d = ~((act_any | (c7mask_q & {8{select_q[7]}} & select_q)) & ~disc_q);

  // capture events only count in capture mode
  assign cap_d = edge_hit & ~select_q;

  // ----------------------------------------------------------------
  // flags: events set, write-one clears, set wins
  // ----------------------------------------------------------------
  wire [7:0] flag_set = (cap_d | (compare_match & select_q)) & CH_IMPL;
  wire [7:0] flag_clr = we_flag ? wmask : 8'h00;
  assign flag_d = (flag_q & ~flag_clr) | flag_set;

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  assign rdata_d = !rd                    ? 8'h00 :
                   (addr == OFS_SELECT)   ? select_q :
                   (addr == OFS_DISC)     ? disc_q :
                   (addr == OFS_C7MASK)   ? c7mask_q :
                   (addr == OFS_C7DATA)   ? c7data_q :
                   (addr == OFS_TOV)      ? tov_q :
                   (addr == OFS_ACT_HI)   ? act_q[15:8] :
                   (addr == OFS_ACT_LO)   ? act_q[7:0] :
                   (addr == OFS_EDGE_HI)  ? edge_q[15:8] :
                   (addr == OFS_EDGE_LO)  ? edge_q[7:0] :
                   (addr == OFS_IEN)      ? ien_q :
                   (addr == OFS_FLAG)     ? flag_q : 8'h00;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      select_q <= REG_RST;
      disc_q   <= REG_RST;
      c7mask_q <= REG_RST;
      c7data_q <= REG_RST;
      tov_q    <= REG_RST;
      act_q    <= {REG_RST, REG_RST};
      edge_q   <= {REG_RST, REG_RST};
      ien_q    <= REG_RST;
    end else begin
      if (we_sel)  select_q <= wmask;
      if (we_disc) disc_q <= wmask;
      if (we_c7m)  c7mask_q <= wmask;
      if (we_c7d)  c7data_q <= wmask;
      if (we_tov)  tov_q <= wmask;
      if (we_ahi)  act_q[15:8] <= wpair_hi;
      if (we_alo)  act_q[7:0] <= wpair_lo;
      if (we_ehi)  edge_q[15:8] <= wpair_hi;
      if (we_elo)  edge_q[7:0] <= wpair_lo;
      if (we_ien)  ien_q <= wmask;
    end
  end

  // status, interrupt and registered outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_q        <= 8'h00;
      irq           <= 1'b0;
      rdata         <= 8'h00;
      pin_oe_n      <= 8'hFF;
      capture_event <= 8'h00;
    end else begin
      flag_q        <= flag_d;
      irq           <= |(flag_q & ien_q);
      rdata         <= rdata_d;
      pin_oe_n      <= oe_n_d;
      capture_event <= cap_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_toggle_action: assert property (
    own_match[0] && !ovr_hit[0] && !wrap_tgl[0] && act_q[1:0] == ACT_TOGGLE
    |=> pin_out[0] != $past(pin_out[0]))
    else $error("toggle action did not flip channel 0");

  a_set_action: assert property (
    own_match[0] && !ovr_hit[0] && !wrap_tgl[0] && act_q[1:0] == ACT_SET
    |=> pin_out[0])
    else $error("set action did not drive channel 0 high");

  a_pin_drive: assert property (
    act_any[0] && !disc_q[0] |=> !pin_oe_n[0])
    else $error("armed channel 0 pin not driven");

  a_disc_release: assert property (
    disc_q[0] |=> pin_oe_n[0])
    else $error("disconnected channel 0 still driven");

  a_ch7_override: assert property (
    ovr_hit[0] |=> pin_out[0] == $past(c7data_q[0]))
    else $error("channel 7 override lost on channel 0");

  a_self_mask: assert property (
    c7_event && c7mask_q[7] |=> pin_out[7] == $past(c7data_q[7]))
    else $error("channel 7 self mask ignored");

  a_flag_event: assert property (
    (compare_match[1] && select_q[1]) || cap_d[1] |=> flag_q[1])
    else $error("event did not set flag 1");

  a_irq_gated: assert property (
    irq |-> $past(|(flag_q & ien_q)))
    else $error("interrupt without enabled flag");

  a_irq_held: assert property (
    (flag_q[0] && ien_q[0]) [*3] |-> irq)
    else $error("interrupt not held with enabled flag");

  a_cap_off: assert property (
    $past(edge_q, 2) == 16'h0000 && $past(edge_q) == 16'h0000 |-> capture_event == 8'h00)
    else $error("capture seen with edges disabled");

  a_reset_zero: assert property (
    $past(reset) |-> act_q == 16'h0000 && edge_q == 16'h0000 && ien_q == 8'h00)
    else $error("control bits not zero after reset");

  // output actions and their priority
  a_clear_action: assert property (
    own_match[0] && !ovr_hit[0] && !wrap_tgl[0] && act_q[1:0] == ACT_CLEAR |=> !pin_out[0])
    else $error("clear action did not drive channel 0 low");

  a_none_action: assert property (
    own_match[0] && !ovr_hit[0] && !wrap_tgl[0] && act_q[1:0] == ACT_NONE |=> $stable(pin_out[0]))
    else $error("no-action code changed channel 0");

  a_wrap_first: assert property (
    wrap_tgl[0] && !ovr_hit[0] |=> pin_out[0] != $past(pin_out[0]))
    else $error("wrap toggle lost on channel 0");

  a_wrap_yields: assert property (
    wrap_tgl[0] && ovr_hit[0] |=> pin_out[0] == $past(c7data_q[0]))
    else $error("wrap toggle beat channel 7 override");

  a_idle_line: assert property (
    !select_q[0] |=> $stable(pin_out[0]))
    else $error("capture channel 0 line moved");

  a_equal_override: assert property (
    ovr_hit[0] && own_match[0] |=> pin_out[0] == $past(c7data_q[0]))
    else $error("equal compare did not take channel 7 data");

  a_later_both: assert property (
    own_match[0] && c7mask_q[0] && !ovr_hit[0] && !wrap_tgl[0] && act_q[1:0] == ACT_CLEAR
    |=> !pin_out[0])
    else $error("own action lost on masked channel 0");

  a_ch7_masked_action: assert property (
    c7_event && c7mask_q[7] && act_q[15:14] == ACT_CLEAR |=> pin_out[7] == $past(c7data_q[7]))
    else $error("channel 7 own action reached masked pin");

  a_override_both: assert property (
    ovr_hit != 8'h00 |-> c7_event && (ovr_hit & ~select_q) == 8'h00)
    else $error("override without both channels in compare");

  a_no_override: assert property (
    compare_match[7] && !select_q[7] |-> ovr_hit == 8'h00)
    else $error("override from channel 7 in capture mode");

  // pin direction
  a_pin_release: assert property (
    act_q[1:0] == ACT_NONE && !c7mask_q[0] |=> pin_oe_n[0])
    else $error("idle channel 0 pin still driven");

  a_pin_override: assert property (
    c7mask_q[0] && select_q[7] && select_q[0] && !disc_q[0] |=> !pin_oe_n[0])
    else $error("override-armed channel 0 pin not driven");

  a_disc_all: assert property (
    disc_q != 8'h00 |=> (pin_oe_n & $past(disc_q)) == $past(disc_q))
    else $error("disconnected pin still driven");

  // capture path
  a_capture_mode: assert property (
    (capture_event & $past(select_q)) == 8'h00)
    else $error("capture event on compare channel");

  a_capture_flag: assert property (
    (capture_event & CH_IMPL & ~flag_q) == 8'h00)
    else $error("capture event without flag");

  // flags and interrupt
  a_flag_sticky: assert property (
    flag_q[0] && !(we_flag && wdata[0]) |=> flag_q[0])
    else $error("flag 0 dropped without clear");

  a_set_wins: assert property (
    flag_set[0] && flag_clr[0] |=> flag_q[0])
    else $error("clear beat event on flag 0");

  a_irq_enabled: assert property (
    flag_q[0] && ien_q[0] |=> irq)
    else $error("enabled flag 0 raised no interrupt");

  a_irq_masked: assert property (
    ien_q == 8'h00 |=> !irq)
    else $error("interrupt with all enables clear");

  a_irq_drop: assert property (
    (flag_q & ien_q) == 8'h00 |=> !irq)
    else $error("interrupt held without enabled flag");

  // register writes, reads and reset
  a_ien_write: assert property (
    we_ien |=> ien_q == $past(wmask))
    else $error("enable register write lost");

  a_edge_write: assert property (
    we_elo |=> edge_q[7:0] == $past(wpair_lo))
    else $error("edge register write lost");

  a_act_write: assert property (
    we_alo |=> act_q[7:0] == $past(wpair_lo))
    else $error("action register write lost");

  a_ien_read: assert property (
    $past(rd) && $past(addr) == OFS_IEN |-> rdata == $past(ien_q))
    else $error("enable register read wrong");

  a_absent_bits: assert property (
    ((select_q | ien_q | flag_q | tov_q) & ~CH_IMPL) == 8'h00)
    else $error("absent channel bit set");

  a_reset_pins: assert property (
    $past(reset) |-> pin_oe_n == 8'hFF && !irq && capture_event == 8'h00)
    else $error("outputs not idle after reset");

  c_override: cover property (ovr_hit != 8'h00);
  c_self_mask: cover property (c7_event && c7mask_q[7]);
  c_irq_rise: cover property ($rose(irq));
  c_capture:  cover property (capture_event != 8'h00);
  c_wrap:     cover property (wrap_tgl != 8'h00 ##1 compare_match != 8'h00);

endmodule // timer_channel_ctrl

// ===== bench/pin_model.sv
// far-side model of the timer channel pins, resolving each wire level
`timescale 1ns/1ps
module pin_model (
  input  wire logic [7:0] drive_lvl,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  output logic      [7:0] pin_in
);
  // external level wins only where the block has released the pin
  assign pin_in = (pin_oe_n & drive_lvl) | (~pin_oe_n & pin_out);
endmodule // pin_model

// ===== bench/testbench.sv
// self-checking bench for the timer channel control block
`timescale 1ns/1ps
module testbench;
  import tmr_chan_pkg::*;
  logic       clk, reset, wr, rd, counter_wrap, irq;
  logic [7:0] addr, wdata, rdata, compare_match, pin_in, pin_out, pin_oe_n, capture_event, lvl;
  int         num_errors, num_checks, cnt;
  logic [7:0] ofs [5] = '{OFS_ACT_HI, OFS_ACT_LO, OFS_EDGE_HI, OFS_EDGE_LO, OFS_IEN};

  timer_channel_ctrl uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .compare_match(compare_match), .counter_wrap(counter_wrap),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .capture_event(capture_event),
    .irq(irq));
  pin_model pins (.drive_lvl(lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic cmp(input logic [7:0] m);
    @(posedge clk); compare_match <= m;
    @(posedge clk); compare_match <= 8'h00;
    #1;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(pin_oe_n, 8'hFF);
    chk({7'h00, irq}, 8'h00);
    foreach (ofs[i]) rchk(ofs[i], 8'h00);
  endtask
  task automatic t_regs;
    foreach (ofs[i]) begin
      wreg(ofs[i], 8'hA5);
      rchk(ofs[i], 8'hA5);
      wreg(ofs[i], 8'h00);
    end
    wreg(8'h05, 8'h5A);
    rchk(8'h05, 8'h00);
    @(posedge clk); #1 chk(rdata, 8'h00);
  endtask
  task automatic t_action;
    logic [1:0] code [5] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE, ACT_NONE};
    logic       exp  [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    wreg(OFS_SELECT, 8'h01);
    foreach (code[i]) begin
      wreg(OFS_ACT_LO, {6'h00, code[i]});
      settle();
      chk({7'h00, pin_oe_n[0]}, {7'h00, code[i] == ACT_NONE});
      cmp(8'h01);
      chk({7'h00, pin_out[0]}, {7'h00, exp[i]});
    end
    wreg(OFS_TOV, 8'h01);
    @(posedge clk); counter_wrap <= 1'b1;
    @(posedge clk); counter_wrap <= 1'b0;
    #1 chk({7'h00, pin_out[0]}, 8'h01);
    wreg(OFS_TOV, 8'h00);
    wreg(OFS_ACT_LO, {6'h00, ACT_SET});
    wreg(OFS_DISC, 8'h01);
    settle();
    chk({7'h00, pin_oe_n[0]}, 8'h01);
    wreg(OFS_DISC, 8'h00);
  endtask
  task automatic t_irq;
    wreg(OFS_FLAG, 8'hFF);
    wreg(OFS_IEN, 8'h00);
    cmp(8'h01);
    rchk(OFS_FLAG, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wreg(OFS_IEN, 8'h01);
    settle();
    chk({7'h00, irq}, 8'h01);
    wreg(OFS_IEN, 8'h02);
    settle();
    chk({7'h00, irq}, 8'h00);
    wreg(OFS_IEN, 8'h01);
    wreg(OFS_FLAG, 8'h01);
    settle();
    chk({7'h00, irq}, 8'h00);
    wreg(OFS_IEN, 8'h00);
  endtask
  task automatic t_capture;
    int exp [4] = '{0, 1, 1, 2};
    wreg(OFS_SELECT, 8'h00);
    wreg(OFS_ACT_LO, 8'h00);
    wreg(OFS_FLAG, 8'hFF);
    for (int c = 0; c < 4; c++) begin
      wreg(OFS_EDGE_LO, 8'(c << 2));
      cnt = 0;
      for (int k = 0; k < 16; k++) begin
        @(posedge clk);
        if (k == 0) lvl <= 8'h02;
        if (k == 8) lvl <= 8'h00;
        #1 if (capture_event[1] === 1'b1) cnt++;
      end
      chk(8'(cnt), 8'(exp[c]));
    end
    rchk(OFS_FLAG, 8'h02);
    wreg(OFS_EDGE_LO, 8'h00);
  endtask
  task automatic t_override;
    wreg(OFS_SELECT, 8'h81);
    wreg(OFS_ACT_LO, {6'h00, ACT_CLEAR});
    wreg(OFS_ACT_HI, {ACT_CLEAR, 6'h00});
    wreg(OFS_C7MASK, 8'h81);
    wreg(OFS_C7DATA, 8'h81);
    cmp(8'h81);
    chk(pin_out & 8'h81, 8'h81);
    cmp(8'h01);
    chk(pin_out & 8'h01, 8'h00);
    cmp(8'h80);
    chk(pin_out & 8'h81, 8'h81);
    wreg(OFS_SELECT, 8'h01);
    cmp(8'h81);
    chk(pin_out & 8'h01, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // clock, verdict, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    reset = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    compare_match = 8'h00; counter_wrap = 1'b0; lvl = 8'h00;
    num_errors = 0; num_checks = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk); #1;
    t_reset();
    t_regs();
    t_action();
    t_irq();
    t_capture();
    t_override();
    give_verdict();
  end
endmodule // testbench
